// [ssw_consts.svh]
// Constants of the satellite switch bus command decoder
`ifndef SSW_CONSTS_SVH
`define SSW_CONSTS_SVH
`define SSW_CHANNELS 4
`define SSW_FRAME_MIN 8'hE0
`define SSW_FRAME_MAX 8'hE7
`define SSW_FRAME_ASK_A 8'hE2
`define SSW_FRAME_ASK_B 8'hE3
`define SSW_REPLY_FRAME 8'hE4
`define SSW_ADDR_ANY 8'h00
`define SSW_ADDR_GROUP 8'h10
`define SSW_ADDR_LNB 8'h11
`define SSW_ADDR_SWITCH 8'h14
`define SSW_CMD_RESET 8'h00
`define SSW_CMD_CLR_RESET 8'h01
`define SSW_CMD_SET_CONTEND 8'h04
`define SSW_CMD_CONTEND 8'h05
`define SSW_CMD_CLR_CONTEND 8'h06
`define SSW_CMD_ADDRESS 8'h07
`define SSW_CMD_MOVE_C 8'h08
`define SSW_CMD_MOVE 8'h09
`define SSW_CMD_STATUS 8'h10
`define SSW_CMD_CONFIG 8'h11
`define SSW_CMD_SWITCH 8'h14
`define SSW_CMD_PICK_LOW_BAND 8'h20
`define SSW_CMD_PICK_VERTICAL 8'h21
`define SSW_CMD_PICK_POS_A 8'h22
`define SSW_CMD_PICK_FIRST_OPTION 8'h23
`define SSW_CMD_PICK_HIGH_BAND 8'h24
`define SSW_CMD_PICK_HORIZONTAL 8'h25
`define SSW_CMD_PICK_POS_B 8'h26
`define SSW_CMD_PICK_SECOND_OPTION 8'h27
`define SSW_CMD_SLEEP 8'h30
`define SSW_CMD_AWAKE 8'h31
`define SSW_SEL_RESET 4'h0
`define SSW_CONFIG_VALUE 8'h03
`define SSW_SWITCH_FIXED 3'h7
`endif

// [ssw_pkg.sv]
// Types shared by the satellite switch bus command decoder
package ssw_pkg;
  // One received byte strobe, or the end-of-frame marker
  typedef struct packed {
    logic valid;
    logic done;
    logic [7:0] data;
  } ssw_rx_type;

  // One reply byte offered to the line driver
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } ssw_tx_type;

  // Routed input: secondary device flag and input number 1..8
  typedef struct packed {
    logic secondary;
    logic [3:0] index;
  } ssw_route_type;

  // Position within a master frame
  typedef enum logic [2:0] {
    RX_FRAMING,
    RX_ADDR,
    RX_CMD,
    RX_DATA,
    RX_EXTRA,
    RX_DROP
  } ssw_rx_state_type;
endpackage : ssw_pkg

// [ssw_decoder.sv]
// Four-channel slave command decoder for the satellite switch control bus
`timescale 1ns/1ns
`include "ssw_consts.svh"

module ssw_decoder
  import ssw_pkg::*;
(
  input wire logic ref_clk, // 125 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic lnb_mode, // 1: LNB mode, 0: single mode
  input wire logic cascade_en, // Cascade inputs available
  input wire logic [`SSW_CHANNELS-1:0] volt_high, // Supply voltage high, per receiver
  input wire logic [`SSW_CHANNELS-1:0] reconnect, // Receiver reconnect pulse
  input wire ssw_rx_type [`SSW_CHANNELS-1:0] rx_in, // Received bytes and frame end
  input wire logic [`SSW_CHANNELS-1:0] tx_ready, // Line driver takes reply byte
  output ssw_tx_type [`SSW_CHANNELS-1:0] tx_out, // Reply bytes
  output ssw_route_type [`SSW_CHANNELS-1:0] route_out, // Routed RF input
  output logic [`SSW_CHANNELS-1:0] bus_ctrl // Channel under bus control
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Fixed address that the current mode answers to
  function automatic logic [7:0] ssw_home_addr(input logic lnb);
    ssw_home_addr = lnb ? `SSW_ADDR_LNB : `SSW_ADDR_SWITCH;
  endfunction : ssw_home_addr

  // Own address and mode address are both taken, so a moved unit still answers home
  // Address filter for one frame
  function automatic logic ssw_addr_ok(input logic [7:0] adr, input logic [7:0] own,
                                       input logic lnb);
    ssw_addr_ok = (adr == `SSW_ADDR_ANY) || (adr == `SSW_ADDR_GROUP)
                  || (adr == own) || (adr == ssw_home_addr(lnb));
  endfunction : ssw_addr_ok

  // Framing byte inside the accepted range
  function automatic logic ssw_frame_ok(input logic [7:0] frm);
    ssw_frame_ok = (frm >= `SSW_FRAME_MIN) && (frm <= `SSW_FRAME_MAX);
  endfunction : ssw_frame_ok

  // ************************************************************
  // Per-channel state
  // ************************************************************

  ssw_rx_state_type rx_state_q [`SSW_CHANNELS];
  logic [7:0] frm_q [`SSW_CHANNELS];
  logic [7:0] adr_q [`SSW_CHANNELS];
  logic [7:0] cmd_q [`SSW_CHANNELS];
  logic [7:0] dat_q [`SSW_CHANNELS];
  logic [7:0] addr_q [`SSW_CHANNELS];
  logic [`SSW_CHANNELS-1:0] init_q;
  logic [`SSW_CHANNELS-1:0] rst_flag_q;
  logic [`SSW_CHANNELS-1:0] contend_q;
  logic [`SSW_CHANNELS-1:0] sleep_q;
  logic [3:0] sel_q [`SSW_CHANNELS];
  logic [`SSW_CHANNELS-1:0] bus_q;
  logic [7:0] rep_q [`SSW_CHANNELS][2];
  logic [1:0] rep_cnt_q [`SSW_CHANNELS];
  logic [`SSW_CHANNELS-1:0] go_c;
  logic [`SSW_CHANNELS-1:0] ok_c;
  logic [`SSW_CHANNELS-1:0] two_c;
  logic [7:0] rdat_c [`SSW_CHANNELS];

  // ************************************************************
  // Frame capture
  // ************************************************************

  // Bytes are placed by position; a bad framing byte drops the rest of the frame
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < `SSW_CHANNELS; i++)
    begin
      if (rst)
      begin
        rx_state_q[i] <= RX_FRAMING;
        frm_q[i] <= 8'h00;
        adr_q[i] <= 8'h00;
        cmd_q[i] <= 8'h00;
        dat_q[i] <= 8'h00;
      end
      else if (rx_in[i].done)
      begin
        rx_state_q[i] <= RX_FRAMING; // Frame end wins over a byte in the same cycle
      end
      else if (rx_in[i].valid)
      begin
        unique case (rx_state_q[i])
          RX_FRAMING:
          begin
            frm_q[i] <= rx_in[i].data;
            rx_state_q[i] <= ssw_frame_ok(rx_in[i].data) ? RX_ADDR : RX_DROP;
          end
          RX_ADDR:
          begin
            adr_q[i] <= rx_in[i].data;
            rx_state_q[i] <= RX_CMD;
          end
          RX_CMD:
          begin
            cmd_q[i] <= rx_in[i].data;
            rx_state_q[i] <= RX_DATA;
          end
          RX_DATA:
          begin
            dat_q[i] <= rx_in[i].data;
            rx_state_q[i] <= RX_EXTRA;
          end
          // A fifth byte or more cannot disturb the latched command or data
          RX_EXTRA, RX_DROP:
          begin
            rx_state_q[i] <= rx_state_q[i]; // Surplus bytes are ignored
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Command decode
  // ************************************************************

  // A frame executes at its end if it held a command, passed the address filter, and the unit is awake or the command is the awake command
  always_comb
  begin
    for (int i = 0; i < `SSW_CHANNELS; i++)
    begin
      go_c[i] = rx_in[i].done
                && ((rx_state_q[i] == RX_DATA) || (rx_state_q[i] == RX_EXTRA))
                && ssw_addr_ok(adr_q[i], addr_q[i], lnb_mode)
                && (!sleep_q[i] || (cmd_q[i] == `SSW_CMD_AWAKE));
      // Conditional commands whose test fails fall silent, like an unknown one
      ok_c[i] = 1'b0;
      two_c[i] = 1'b0;
      rdat_c[i] = 8'h00;
      unique case (cmd_q[i])
        `SSW_CMD_RESET, `SSW_CMD_CLR_RESET, `SSW_CMD_SET_CONTEND, `SSW_CMD_CLR_CONTEND,
        `SSW_CMD_SLEEP, `SSW_CMD_AWAKE:
          ok_c[i] = 1'b1;
        `SSW_CMD_CONTEND:
        begin
          ok_c[i] = contend_q[i];
          two_c[i] = 1'b1;
          rdat_c[i] = addr_q[i];
        end
        `SSW_CMD_ADDRESS:
        begin
          ok_c[i] = !contend_q[i];
          two_c[i] = 1'b1;
          rdat_c[i] = addr_q[i];
        end
        `SSW_CMD_MOVE_C:
          ok_c[i] = contend_q[i] && (rx_state_q[i] == RX_EXTRA);
        `SSW_CMD_MOVE:
          ok_c[i] = !contend_q[i] && (rx_state_q[i] == RX_EXTRA);
        `SSW_CMD_STATUS:
        begin
          ok_c[i] = 1'b1;
          two_c[i] = 1'b1;
          rdat_c[i] = {contend_q[i], 4'h0, volt_high[i], sleep_q[i], rst_flag_q[i]};
        end
        `SSW_CMD_CONFIG:
        begin
          ok_c[i] = 1'b1;
          two_c[i] = 1'b1;
          rdat_c[i] = `SSW_CONFIG_VALUE;
        end
        `SSW_CMD_SWITCH:
        begin
          ok_c[i] = 1'b1;
          two_c[i] = 1'b1;
          rdat_c[i] = {sel_q[i], cascade_en, `SSW_SWITCH_FIXED};
        end
        `SSW_CMD_PICK_LOW_BAND, `SSW_CMD_PICK_VERTICAL, `SSW_CMD_PICK_POS_A,
        `SSW_CMD_PICK_FIRST_OPTION, `SSW_CMD_PICK_HIGH_BAND, `SSW_CMD_PICK_HORIZONTAL,
        `SSW_CMD_PICK_POS_B, `SSW_CMD_PICK_SECOND_OPTION:
          ok_c[i] = 1'b1;
        default:
          ok_c[i] = 1'b0; // Unknown command is dropped
      endcase
    end
  end

  // ************************************************************
  // Decoder registers
  // ************************************************************

  // Status, address and selection; the home address is caught one cycle after reset
  // since the mode strap may not be settled while reset is held
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < `SSW_CHANNELS; i++)
    begin
      if (rst)
      begin
        init_q[i] <= 1'b0;
        addr_q[i] <= `SSW_ADDR_SWITCH;
        rst_flag_q[i] <= 1'b1;
        contend_q[i] <= 1'b0;
        sleep_q[i] <= 1'b0;
        sel_q[i] <= `SSW_SEL_RESET;
      end
      else if (!init_q[i])
      begin
        init_q[i] <= 1'b1;
        addr_q[i] <= ssw_home_addr(lnb_mode);
      end
      // A frame ending in the settle cycle after reset is lost, so masters must wait
      else if (go_c[i] && ok_c[i])
      begin
        unique case (cmd_q[i])
          `SSW_CMD_RESET:
          begin
            addr_q[i] <= ssw_home_addr(lnb_mode);
            rst_flag_q[i] <= 1'b1;
            contend_q[i] <= 1'b0;
            sleep_q[i] <= 1'b0;
            sel_q[i] <= `SSW_SEL_RESET;
          end
          `SSW_CMD_CLR_RESET: rst_flag_q[i] <= 1'b0;
          `SSW_CMD_SET_CONTEND: contend_q[i] <= 1'b1;
          `SSW_CMD_CLR_CONTEND: contend_q[i] <= 1'b0;
          `SSW_CMD_MOVE_C, `SSW_CMD_MOVE: addr_q[i] <= dat_q[i];
          `SSW_CMD_SLEEP: sleep_q[i] <= 1'b1;
          `SSW_CMD_AWAKE: sleep_q[i] <= 1'b0;
          `SSW_CMD_PICK_LOW_BAND, `SSW_CMD_PICK_VERTICAL, `SSW_CMD_PICK_POS_A,
          `SSW_CMD_PICK_FIRST_OPTION, `SSW_CMD_PICK_HIGH_BAND, `SSW_CMD_PICK_HORIZONTAL,
          `SSW_CMD_PICK_POS_B, `SSW_CMD_PICK_SECOND_OPTION:
            sel_q[i][cmd_q[i][1:0]] <= cmd_q[i][2];
          default: sel_q[i] <= sel_q[i];
        endcase
      end
    end
  end

  // ************************************************************
  // Control source
  // ************************************************************

  // The decoder reset command leaves this flag alone; only a reconnect or rst hands control back
  // A valid framing byte hands the channel to the bus; a frame in the reconnect cycle wins
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < `SSW_CHANNELS; i++)
    begin
      if (rst)
      begin
        bus_q[i] <= 1'b0;
      end
      else if (rx_in[i].valid && !rx_in[i].done && (rx_state_q[i] == RX_FRAMING)
               && ssw_frame_ok(rx_in[i].data))
      begin
        bus_q[i] <= 1'b1;
      end
      else if (reconnect[i])
      begin
        bus_q[i] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Reply path
  // ************************************************************

  // Reply is loaded only for a reply-requesting framing byte; a new reply replaces an old one
  // The line driver may stall any byte; the head byte simply stands until taken
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < `SSW_CHANNELS; i++)
    begin
      if (rst)
      begin
        rep_cnt_q[i] <= 2'h0;
        rep_q[i][0] <= 8'h00;
        rep_q[i][1] <= 8'h00;
      end
      else if (go_c[i] && ok_c[i]
               && ((frm_q[i] == `SSW_FRAME_ASK_A) || (frm_q[i] == `SSW_FRAME_ASK_B)))
      begin
        rep_q[i][0] <= `SSW_REPLY_FRAME;
        rep_q[i][1] <= rdat_c[i];
        rep_cnt_q[i] <= two_c[i] ? 2'h2 : 2'h1;
      end
      else if ((rep_cnt_q[i] != 2'h0) && tx_ready[i])
      begin
        // Shift the data byte forward; the stale copy left behind is never shown
        rep_q[i][0] <= rep_q[i][1];
        rep_cnt_q[i] <= rep_cnt_q[i] - 2'h1;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Route index from the selection flops: option picks the device, the rest the input
  always_comb
  begin
    for (int i = 0; i < `SSW_CHANNELS; i++)
    begin
      route_out[i].secondary = sel_q[i][3];
      // Satellite, band and polarization packed in weight order so one add gives 1..8
      route_out[i].index = {1'b0, sel_q[i][2], sel_q[i][0], sel_q[i][1]} + 4'h1;
      // Valid and last follow the count, so both drop with the final take
      tx_out[i].valid = (rep_cnt_q[i] != 2'h0);
      tx_out[i].last = (rep_cnt_q[i] == 2'h1);
      tx_out[i].data = rep_q[i][0];
    end
  end

  assign bus_ctrl = bus_q;

endmodule : ssw_decoder

// [ssw_decoder_props.sv]
// Port checker for the four-channel bus command decoder
`timescale 1ns/1ns
`include "ssw_consts.svh"

module ssw_decoder_chk
  import ssw_pkg::*;
(
  input wire logic ref_clk, // Decoder clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [`SSW_CHANNELS-1:0] reconnect, // Reconnect pulses
  input wire ssw_rx_type [`SSW_CHANNELS-1:0] rx_in, // Received bytes
  input wire logic [`SSW_CHANNELS-1:0] tx_ready, // Reply byte taken
  input wire ssw_tx_type [`SSW_CHANNELS-1:0] tx_out, // Reply bytes
  input wire ssw_route_type [`SSW_CHANNELS-1:0] route_out, // Routed input
  input wire logic [`SSW_CHANNELS-1:0] bus_ctrl // Bus control flags
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ***
  // Per-channel checks, channels must not leak into each other
  // ***
  for (genvar c = 0; c < `SSW_CHANNELS; c++)
  begin : g_ch
    chk_route_span: assert property (route_out[c].index inside {[4'h1:4'h8]})
      else $error("routed input outside one to eight");
    chk_route_step: assert property (!$stable(route_out[c]) |-> (route_out[c] == 5'h01)
      || ($countones({route_out[c].secondary, route_out[c].index - 4'h1}
      ^ {$past(route_out[c].secondary), $past(route_out[c].index) - 4'h1}) == 1))
      else $error("route moved more than one selection bit");
    chk_reset_idle: assert property ($fell(rst) |-> route_out[c].index == 4'h1
      && !route_out[c].secondary && !bus_ctrl[c] && !tx_out[c].valid)
      else $error("state after reset not idle");
    chk_bus_cause: assert property ($rose(bus_ctrl[c]) |-> $past(rx_in[c].valid)
      && $past(rx_in[c].data) inside {[8'hE0:8'hE7]})
      else $error("bus control taken without framing byte");
    chk_bus_drop: assert property (reconnect[c] && !rx_in[c].valid |=> !bus_ctrl[c])
      else $error("bus control kept after reconnect");
    chk_reply_cause: assert property ($rose(tx_out[c].valid) |-> $past(rx_in[c].done))
      else $error("reply started without frame end");
    chk_reply_head: assert property ($rose(tx_out[c].valid) |-> tx_out[c].data == 8'hE4)
      else $error("reply does not open with framing byte");
    chk_reply_hold: assert property (tx_out[c].valid && !tx_ready[c] && !rx_in[c].done
      |=> tx_out[c].valid && $stable(tx_out[c].data) && $stable(tx_out[c].last))
      else $error("stalled reply byte changed");
    chk_reply_end: assert property (tx_out[c].valid && tx_out[c].last && tx_ready[c]
      && !rx_in[c].done |=> !tx_out[c].valid)
      else $error("reply continues after last byte");
    chk_route_quiet: assert property (!$stable(route_out[c]) |-> $past(rx_in[c].done))
      else $error("route changed outside a frame end");
  end
endmodule : ssw_decoder_chk

bind ssw_decoder ssw_decoder_chk u_chk (.ref_clk(ref_clk), .rst(rst), .reconnect(reconnect),
  .rx_in(rx_in), .tx_ready(tx_ready), .tx_out(tx_out), .route_out(route_out),
  .bus_ctrl(bus_ctrl));

// [ssw_rcv_model.sv]
// Receiver-side model that sends master frames and takes reply bytes
`timescale 1ns/1ns
`include "ssw_consts.svh"

module ssw_rcv_model
  import ssw_pkg::*;
(
  input wire logic ref_clk, // Bench clock
  input wire ssw_tx_type [`SSW_CHANNELS-1:0] tx_out, // Reply bytes
  output ssw_rx_type [`SSW_CHANNELS-1:0] rx_in, // Frame bytes
  output logic [`SSW_CHANNELS-1:0] tx_ready // Reply byte taken
);
  logic slow; // Drop ready on every other cycle when set, so each reply byte is stalled
  int last_at; // Position of the taken reply byte that carried the last flag

  // Idle link at start
  initial
  begin
    slow = 1'b0;
    rx_in = '0;
    tx_ready = '0;
  end

  // ***
  // Frame transfer
  // ***
  // First nb of framing, address, command, data, then end marker
  task automatic xfer(input int ch, input logic [7:0] b [4], input int nb,
                      output int n, output logic [7:0] r [2]);
    n = 0;
    last_at = 0;
    r = '{8'h00, 8'h00};
    for (int i = 0; i < nb; i++)
    begin
      @(posedge ref_clk);
      rx_in[ch] <= {1'b1, 1'b0, b[i]};
    end
    @(posedge ref_clk);
    rx_in[ch] <= {1'b0, 1'b1, ~b[nb-1]}; // Idle data inverted so stale bytes never match
    // Window long enough for two stalled bytes; ready drops before it closes
    for (int k = 0; k < 12; k++)
    begin
      @(posedge ref_clk);
      rx_in[ch] <= {1'b0, 1'b0, ~b[nb-1]};
      if (tx_out[ch].valid && tx_ready[ch])
      begin
        if (n < 2) r[n] = tx_out[ch].data;
        if (tx_out[ch].last) last_at = n + 1;
        n++;
      end
      tx_ready[ch] <= (k < 11) && (!slow || k[0]);
    end
  endtask : xfer
endmodule : ssw_rcv_model

// [test_ssw_decoder.sv]
// Self-checking bench for the four-channel bus command decoder
`timescale 1ns/1ns
`include "ssw_consts.svh"

module test_ssw_decoder
  import ssw_pkg::*;
;
  logic ref_clk;
  logic rst;
  logic lnb_mode;
  logic cascade_en;
  logic [`SSW_CHANNELS-1:0] volt_high;
  logic [`SSW_CHANNELS-1:0] reconnect;
  ssw_rx_type [`SSW_CHANNELS-1:0] rx_in;
  logic [`SSW_CHANNELS-1:0] tx_ready;
  ssw_tx_type [`SSW_CHANNELS-1:0] tx_out;
  ssw_route_type [`SSW_CHANNELS-1:0] route_out;
  logic [`SSW_CHANNELS-1:0] bus_ctrl;
  int num_errors;
  int checked;
  logic [7:0] sel;

  ssw_decoder dut (.ref_clk(ref_clk), .rst(rst), .lnb_mode(lnb_mode), .cascade_en(cascade_en),
    .volt_high(volt_high), .reconnect(reconnect), .rx_in(rx_in), .tx_ready(tx_ready),
    .tx_out(tx_out), .route_out(route_out), .bus_ctrl(bus_ctrl));

  ssw_rcv_model m (.ref_clk(ref_clk), .tx_out(tx_out), .rx_in(rx_in), .tx_ready(tx_ready));

  // 125 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ***
  // Shared tasks
  // ***
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One frame and its reply; en is the reply length expected
  task automatic fr(input int ch, input logic [7:0] f, input logic [7:0] a,
                    input logic [7:0] c, input int en, input logic [7:0] e1 = 8'h00,
                    input logic [7:0] d = 8'h00, input int nb = 3);
    logic [7:0] r [2];
    int n;
    m.xfer(ch, '{f, a, c, d}, nb, n, r);
    check("reply length", 8'(n), 8'(en));
    check("reply last", 8'(m.last_at), 8'(en));
    if (en > 0) check("reply framing", r[0], 8'hE4);
    if (en > 1) check("reply data", r[1], e1);
  endtask : fr

  task automatic route_is(input logic [4:0] e);
    check("route", {3'h0, route_out[0]}, {3'h0, e});
  endtask : route_is

  // Verdict; the only place the run ends
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // ***
  // Main sequence
  // ***
  initial
  begin
    num_errors = 0;
    checked = 0;
    rst = 1'b1;
    lnb_mode = 1'b1;
    cascade_en = 1'b1;
    volt_high = 4'h1;
    reconnect = 4'h0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    route_is(5'h01);
    check("bus control", {4'h0, bus_ctrl}, 8'h00);
    fr(0, 8'hE2, 8'h10, 8'h07, 2, 8'h11);
    check("bus control", {4'h0, bus_ctrl}, 8'h01);
    fr(0, 8'hE3, 8'h00, 8'h10, 2, 8'h05);
    fr(0, 8'hE3, 8'h11, 8'h01, 1);
    fr(0, 8'hE3, 8'h11, 8'h10, 2, 8'h04);
    fr(0, 8'hE3, 8'h14, 8'h10, 0);
    fr(0, 8'hE0, 8'h10, 8'h07, 0);
    fr(0, 8'hD0, 8'h10, 8'h07, 0);
    fr(0, 8'hE3, 8'h10, 8'h15, 0);
    fr(0, 8'hE3, 8'h10, 8'h07, 0, 8'h00, 8'h00, 2);
    // Contention flag gates each address command one way
    fr(0, 8'hE3, 8'h10, 8'h05, 0);
    fr(0, 8'hE3, 8'h10, 8'h04, 1);
    fr(0, 8'hE3, 8'h10, 8'h05, 2, 8'h11);
    fr(0, 8'hE3, 8'h10, 8'h07, 0);
    fr(0, 8'hE3, 8'h10, 8'h09, 0, 8'h00, 8'h42, 4);
    fr(0, 8'hE3, 8'h10, 8'h08, 1, 8'h00, 8'h5A, 4);
    fr(0, 8'hE3, 8'h10, 8'h10, 2, 8'h84);
    fr(0, 8'hE3, 8'h10, 8'h06, 1);
    fr(0, 8'hE3, 8'h5A, 8'h07, 2, 8'h5A);
    fr(1, 8'hE3, 8'h10, 8'h07, 2, 8'h11);
    check("bus control", {4'h0, bus_ctrl}, 8'h03);
    fr(0, 8'hE3, 8'h10, 8'h08, 0, 8'h00, 8'h6B, 4);
    fr(0, 8'hE3, 8'h10, 8'h09, 1, 8'h00, 8'h11, 4);
    fr(0, 8'hE3, 8'h10, 8'h11, 2, 8'h03);
    // Walk all sixteen inputs with every selection command
    for (int i = 0; i < 16; i++)
    begin
      sel = 8'(i);
      fr(0, 8'hE0, 8'h10, {5'h04, sel[3], 2'h3}, 0);
      fr(0, 8'hE0, 8'h10, {5'h04, sel[2], 2'h2}, 0);
      fr(0, 8'hE0, 8'h10, {5'h04, sel[1], 2'h0}, 0);
      fr(0, 8'hE0, 8'h10, {5'h04, sel[0], 2'h1}, 0);
      route_is({sel[3], sel[2:0] + 4'h1});
    end
    fr(0, 8'hE2, 8'h10, 8'h20, 1);
    route_is(5'h16);
    check("route ch1", {3'h0, route_out[1]}, 8'h01);
    m.slow = 1'b1;
    fr(0, 8'hE3, 8'h10, 8'h14, 2, 8'hEF);
    m.slow = 1'b0;
    cascade_en <= 1'b0;
    fr(0, 8'hE3, 8'h10, 8'h14, 2, 8'hE7);
    cascade_en <= 1'b1;
    fr(0, 8'hE3, 8'h10, 8'h30, 1);
    fr(0, 8'hE0, 8'h10, 8'h24, 0);
    route_is(5'h16);
    fr(0, 8'hE3, 8'h10, 8'h10, 0);
    fr(0, 8'hE3, 8'h10, 8'h31, 1);
    fr(0, 8'hE3, 8'h10, 8'h10, 2, 8'h04);
    volt_high <= 4'h0;
    fr(0, 8'hE3, 8'h10, 8'h10, 2, 8'h00);
    volt_high <= 4'h1;
    fr(0, 8'hE3, 8'h10, 8'h00, 1);
    route_is(5'h01);
    fr(0, 8'hE3, 8'h10, 8'h10, 2, 8'h05);
    // Single mode takes the switcher address after a decoder reset
    @(posedge ref_clk);
    lnb_mode <= 1'b0;
    fr(0, 8'hE0, 8'h10, 8'h00, 0);
    fr(0, 8'hE3, 8'h14, 8'h07, 2, 8'h14);
    fr(0, 8'hE3, 8'h11, 8'h07, 0);
    @(posedge ref_clk);
    reconnect <= 4'h1;
    @(posedge ref_clk);
    reconnect <= 4'h0;
    @(posedge ref_clk);
    check("bus control", {4'h0, bus_ctrl}, 8'h02);
    results();
  end
endmodule : test_ssw_decoder
